// File: logic/lrr_pkg.sv
// Purpose: Shared constants and types for the logical unit reset message handler.
// Assumes: Messages move byte-serially, one byte per cycle with a last marker.
// Notes:   Both ends and the bench use these names.
package lrr_pkg;
	// ==========================================================
	// Message codes
	localparam logic [7:0] LRR_CLASS_CODE       = 8'h83;
	localparam logic [7:0] LRR_SUB_LUN_RESET    = 8'h35;
	localparam logic [7:0] LRR_SUB_RESPONSE     = 8'h03;
	localparam logic [7:0] LRR_SUB_COMMAND      = 8'h01;
	// ==========================================================
	// Return codes
	localparam logic [7:0] LRR_RC_SUCCESS       = 8'h00;
	localparam logic [7:0] LRR_RC_TASK_NOT_FOUND = 8'h01;
	localparam logic [7:0] LRR_RC_OVERLAPPED    = 8'h04;
	localparam logic [7:0] LRR_RC_NO_ALLEGIANCE = 8'h20;
	localparam logic [7:0] LRR_RC_INVALID       = 8'hff;
	// ==========================================================
	// Field layout
	localparam int         LRR_REQ_LEN          = 9;
	localparam int         LRR_RSP_LEN          = 5;
	localparam int         LRR_CMD_QCTL_BYTE    = 8;
	localparam logic [7:0] LRR_QCTL_UNTAGGED    = 8'h00;
	localparam logic [7:0] LRR_QCTL_SIMPLE      = 8'h01;
	localparam int         LRR_LUN_COUNT        = 8;
	localparam logic [7:0] LRR_ASC_POWER_ON     = 8'h29;
	// ==========================================================
	// Transport reset kinds
	typedef enum logic [2:0] {
		LRR_RST_NONE     = 3'h0,
		LRR_RST_LINK     = 3'h1,
		LRR_RST_TOTAL    = 3'h2,
		LRR_RST_ABSOLUTE = 3'h3,
		LRR_RST_POWER_ON = 3'h4,
		LRR_RST_LOCAL    = 3'h5
	} lrr_rst_kind_t;
endpackage

// File: logic/lrr_link_if.sv
// Purpose: Byte-serial link between initiator layer and target layer.
// Assumes: One clock; valid/ready handshake per byte in each direction.
// Notes:   Reply path id travels with each response on rsp_path.
`timescale 1ns/1ps
interface lrr_link_if;
	// Request stream, initiator to target
	logic        req_valid;
	logic        req_ready;
	logic [7:0]  req_data;
	logic        req_last;
	logic [31:0] req_path;
	// Response stream, target to initiator
	logic        rsp_valid;
	logic        rsp_ready;
	logic [7:0]  rsp_data;
	logic        rsp_last;
	logic [31:0] rsp_path;
	// Completion status and unit attention notices
	logic        status_valid;
	logic [15:0] status_tag;
	logic        attention;
	logic [7:0]  attention_sense;

	modport target (
		input  req_valid, req_data, req_last, req_path, rsp_ready,
		output req_ready, rsp_valid, rsp_data, rsp_last, rsp_path,
		output status_valid, status_tag, attention, attention_sense
	);
	modport initiator (
		output req_valid, req_data, req_last, req_path, rsp_ready,
		input  req_ready, rsp_valid, rsp_data, rsp_last, rsp_path,
		input  status_valid, status_tag, attention, attention_sense
	);
endinterface

// File: logic/lrr_initiator.sv
// Purpose: Initiator end: sends one reset request per path and retires tasks.
// Assumes: User starts a reset with a one-cycle pulse; paths given as a list.
// Notes:   Outbound data is stopped by the user before start is pulsed.
`timescale 1ns/1ps
module lrr_initiator (
	// Clock and reset
	input  wire logic             mclk_in,
	input  wire logic             reset_n_in,
	// User side
	input  wire logic             start_in,
	input  wire logic [15:0]      tag_in,
	input  wire logic [7:0]       lun_in,
	input  wire logic [1:0]       path_count_in,
	input  wire logic [3:0][31:0] paths_in,
	input  wire logic             data_quiet_in,
	output logic                  busy_out,
	output logic                  done_out,
	output logic [7:0]            rcode_out,
	output logic                  purge_out,
	output logic [7:0]            purge_lun_out,
	// Link
	lrr_link_if.initiator         link
);
	// ==========================================================
	// State
	typedef enum logic [1:0] {
		LRR_I_IDLE = 2'b00,
		LRR_I_SEND = 2'b01,
		LRR_I_WAIT = 2'b11
	} lrr_i_state_t;

	lrr_i_state_t state_reg, state_next;
	logic [3:0]   idx_reg, idx_next;
	logic [1:0]   pth_reg, pth_next;
	logic [2:0]   rix_reg, rix_next;
	logic [15:0]  tag_reg, tag_next;
	logic [7:0]   lun_reg, lun_next;
	logic [7:0]   rc_reg, rc_next;
	logic         done_reg, done_next;
	logic         purge_reg, purge_next;
	logic [7:0]   byte_w;
	logic [31:0]  path_w;

	// Request bytes built from the held tag and unit and the live paths_in entry for the current path
	always_comb begin
		path_w = paths_in[pth_reg];
		unique case (idx_reg)
			4'h0: byte_w = lrr_pkg::LRR_CLASS_CODE;
			4'h1: byte_w = lrr_pkg::LRR_SUB_LUN_RESET;
			4'h2: byte_w = tag_reg[15:8];
			4'h3: byte_w = tag_reg[7:0];
			4'h4: byte_w = path_w[31:24];
			4'h5: byte_w = path_w[23:16];
			4'h6: byte_w = path_w[15:8];
			4'h7: byte_w = path_w[7:0];
			default: byte_w = lun_reg;
		endcase
	end

	// Next-state: one request per path, each answered before the next
	always_comb begin
		state_next = state_reg;
		idx_next   = idx_reg;
		pth_next   = pth_reg;
		rix_next   = rix_reg;
		tag_next   = tag_reg;
		lun_next   = lun_reg;
		rc_next    = rc_reg;
		done_next  = 1'b0;
		purge_next = 1'b0;
		unique case (state_reg)
			LRR_I_IDLE: begin
				if (start_in && data_quiet_in) begin
					state_next = LRR_I_SEND;
					tag_next   = tag_in;
					lun_next   = lun_in;
					idx_next   = 4'h0;
					pth_next   = 2'h0;
				end
			end
			LRR_I_SEND: begin
				if (link.req_ready) begin
					if (idx_reg == 4'(lrr_pkg::LRR_REQ_LEN - 1)) begin
						state_next = LRR_I_WAIT;
						rix_next   = 3'h0;
					end else begin
						idx_next = idx_reg + 4'h1;
					end
				end
			end
			LRR_I_WAIT: begin
				if (link.rsp_valid) begin
					rix_next = rix_reg + 3'h1;
					if (rix_reg == 3'h4) begin
						rc_next = link.rsp_data;
					end
					if (link.rsp_last) begin
						if (pth_reg == path_count_in) begin
							state_next = LRR_I_IDLE;
							done_next  = 1'b1;
							purge_next = 1'b1;
						end else begin
							pth_next   = pth_reg + 2'h1;
							idx_next   = 4'h0;
							state_next = LRR_I_SEND;
						end
					end
				end
			end
			default: state_next = LRR_I_IDLE;
		endcase
	end

	// Registers
	always_ff @(posedge mclk_in) begin
		if (!reset_n_in) begin
			state_reg <= LRR_I_IDLE;
			idx_reg   <= 4'h0;
			pth_reg   <= 2'h0;
			rix_reg   <= 3'h0;
			tag_reg   <= 16'h0000;
			lun_reg   <= 8'h00;
			rc_reg    <= 8'h00;
			done_reg  <= 1'b0;
			purge_reg <= 1'b0;
		end else begin
			state_reg <= state_next;
			idx_reg   <= idx_next;
			pth_reg   <= pth_next;
			rix_reg   <= rix_next;
			tag_reg   <= tag_next;
			lun_reg   <= lun_next;
			rc_reg    <= rc_next;
			done_reg  <= done_next;
			purge_reg <= purge_next;
		end
	end

	// Link and user outputs
	assign link.req_valid = (state_reg == LRR_I_SEND);
	assign link.req_data  = byte_w;
	assign link.req_last  = (idx_reg == 4'(lrr_pkg::LRR_REQ_LEN - 1));
	assign link.req_path  = path_w;
	assign link.rsp_ready = 1'b1;
	assign busy_out       = (state_reg != LRR_I_IDLE);
	assign done_out       = done_reg;
	assign rcode_out      = rc_reg;
	assign purge_out      = purge_reg;
	assign purge_lun_out  = lun_reg;
endmodule

// File: logic/lrr_target.sv
// Purpose: Target end: takes reset and command messages, resets the unit, replies.
// Assumes: Task store and mode store sit outside; this block steers them by pulses.
// Notes:   Commands are only screened for the queue control field here.
//
// Contract
// - Reset request: 83h, 35h, tag, path, unit
// - Abort all tasks of addressed unit only
// - Clear allegiance conditions on that unit
// - Release reservations held on that unit
// - Restore saved modes, else defaults
// - Leave transport tables and alerts alone
// - Flush requested data before aborting tasks
// - Completed status before reply, none after
// - Unit attention to all, power-on sense
// - Exactly one reply per reset request
// - Initiator sends one request per path
// - Initiator stops outbound data first
// - Initiator drops aborted commands on reply
// - Tag echoed to match reply
// - Reply on the path from request
// - Bad unit gives FFh, else 00h
// - Reply: 83h, 03h, tag, return code
// - Return code encoding per defined values
// - Reply acknowledges task management, bad commands
// - Link reset keeps state; others reinitialise
// - Every command tagged, untagged forbidden
`timescale 1ns/1ps
module lrr_target (
	// Clock and reset
	input  wire logic                 mclk_in,
	input  wire logic                 reset_n_in,
	// Unit side
	input  wire logic [7:0]           lun_attached_in,
	input  wire logic                 data_pending_in,
	input  wire logic                 task_done_in,
	input  wire logic [15:0]          task_done_tag_in,
	input  wire logic [7:0]           task_done_lun_in,
	input  wire lrr_pkg::lrr_rst_kind_t transport_reset_in,
	output logic                      flush_out,
	output logic                      abort_out,
	output logic                      clear_allegiance_out,
	output logic                      release_reservation_out,
	output logic                      restore_modes_out,
	output logic [7:0]                unit_out,
	output logic                      reinit_out,
	output logic                      command_out,
	// Link
	lrr_link_if.target                link
);
	// ==========================================================
	// State
	typedef enum logic [2:0] {
		LRR_T_RECV  = 3'b000,
		LRR_T_CHECK = 3'b001,
		LRR_T_FLUSH = 3'b011,
		LRR_T_RESET = 3'b010,
		LRR_T_REPLY = 3'b110
	} lrr_t_state_t;

	lrr_t_state_t state_reg, state_next;
	logic [3:0]   idx_reg, idx_next;
	logic [7:0]   sub_reg, sub_next;
	logic [15:0]  tag_reg, tag_next;
	logic [31:0]  path_reg, path_next;
	logic [7:0]   lun_reg, lun_next;
	logic [7:0]   qctl_reg, qctl_next;
	logic [7:0]   rc_reg, rc_next;
	logic         blk_reg, blk_next;
	logic [6:0]   pulse_reg, pulse_next;
	logic         stat_v_reg, stat_v_next;
	logic [15:0]  stat_tag_reg, stat_tag_next;
	logic         att_reg, att_next;
	logic         reinit_req;
	logic [7:0]   rsp_byte;

	// Unit index must name an attached unit inside the supported range
	function automatic logic lun_ok(input logic [7:0] lun, input logic [7:0] att);
		lun_ok = (lun < 8'(lrr_pkg::LRR_LUN_COUNT)) && att[lun[2:0]];
	endfunction

	// Link reset is ignored; every other kind rebuilds the layer
	assign reinit_req = (transport_reset_in != lrr_pkg::LRR_RST_NONE) &&
	                    (transport_reset_in != lrr_pkg::LRR_RST_LINK);

	// Response bytes
	always_comb begin
		unique case (idx_reg)
			4'h0: rsp_byte = lrr_pkg::LRR_CLASS_CODE;
			4'h1: rsp_byte = lrr_pkg::LRR_SUB_RESPONSE;
			4'h2: rsp_byte = tag_reg[15:8];
			4'h3: rsp_byte = tag_reg[7:0];
			default: rsp_byte = rc_reg;
		endcase
	end

	// Next-state of the message engine
	always_comb begin
		state_next    = state_reg;
		idx_next      = idx_reg;
		sub_next      = sub_reg;
		tag_next      = tag_reg;
		path_next     = path_reg;
		lun_next      = lun_reg;
		qctl_next     = qctl_reg;
		rc_next       = rc_reg;
		blk_next      = blk_reg;
		pulse_next    = 7'h00;
		att_next      = att_reg;
		// Completed tasks report until the reply has gone, then aborted ones stay quiet
		stat_v_next   = task_done_in && !(blk_reg && task_done_lun_in == lun_reg);
		stat_tag_next = task_done_tag_in;
		unique case (state_reg)
			LRR_T_RECV: begin
				if (link.req_valid) begin
					idx_next = idx_reg + 4'h1;
					unique case (idx_reg)
						4'h1: sub_next = link.req_data;
						4'h2: tag_next[15:8] = link.req_data;
						4'h3: tag_next[7:0] = link.req_data;
						4'h4: path_next[31:24] = link.req_data;
						4'h5: path_next[23:16] = link.req_data;
						4'h6: path_next[15:8] = link.req_data;
						4'h7: path_next[7:0] = link.req_data;
						4'h8: begin
							lun_next  = link.req_data;
							qctl_next = link.req_data;
						end
						default: ;
					endcase
					if (link.req_last) begin
						state_next = LRR_T_CHECK;
						idx_next   = 4'h0;
					end
				end
			end
			LRR_T_CHECK: begin
				if (sub_reg == lrr_pkg::LRR_SUB_LUN_RESET) begin
					if (lun_ok(lun_reg, lun_attached_in)) begin
						rc_next    = lrr_pkg::LRR_RC_SUCCESS;
						state_next = LRR_T_FLUSH;
					end else begin
						rc_next    = lrr_pkg::LRR_RC_INVALID;
						state_next = LRR_T_REPLY;
					end
				end else if (sub_reg == lrr_pkg::LRR_SUB_COMMAND &&
				             qctl_reg == lrr_pkg::LRR_QCTL_UNTAGGED) begin
					rc_next    = lrr_pkg::LRR_RC_INVALID;
					state_next = LRR_T_REPLY;
				end else begin
					pulse_next[6] = (sub_reg == lrr_pkg::LRR_SUB_COMMAND);
					state_next    = LRR_T_RECV;
				end
			end
			LRR_T_FLUSH: begin
				pulse_next[0] = 1'b1;
				if (!data_pending_in) begin
					state_next = LRR_T_RESET;
				end
			end
			LRR_T_RESET: begin
				// Only the addressed unit is touched; transport state is not ours
				pulse_next[4:1] = 4'hf;
				att_next        = 1'b1;
				state_next      = LRR_T_REPLY;
			end
			LRR_T_REPLY: begin
				if (link.rsp_ready) begin
					if (idx_reg == 4'(lrr_pkg::LRR_RSP_LEN - 1)) begin
						state_next = LRR_T_RECV;
						idx_next   = 4'h0;
						blk_next   = (rc_reg == lrr_pkg::LRR_RC_SUCCESS) &&
						             (sub_reg == lrr_pkg::LRR_SUB_LUN_RESET);
					end else begin
						idx_next = idx_reg + 4'h1;
					end
				end
			end
			default: state_next = LRR_T_RECV;
		endcase
		if (reinit_req) begin
			pulse_next[5] = 1'b1;
			att_next      = 1'b1;
		end
	end

	// Registers; a reinitialising transport reset also drops the message engine
	always_ff @(posedge mclk_in) begin
		if (!reset_n_in || reinit_req) begin
			state_reg <= LRR_T_RECV;
			idx_reg   <= 4'h0;
			sub_reg   <= 8'h00;
			tag_reg   <= 16'h0000;
			path_reg  <= 32'h0000_0000;
			lun_reg   <= 8'h00;
			qctl_reg  <= 8'h00;
			rc_reg    <= 8'h00;
			blk_reg   <= 1'b0;
		end else begin
			state_reg <= state_next;
			idx_reg   <= idx_next;
			sub_reg   <= sub_next;
			tag_reg   <= tag_next;
			path_reg  <= path_next;
			lun_reg   <= lun_next;
			qctl_reg  <= qctl_next;
			rc_reg    <= rc_next;
			blk_reg   <= blk_next;
		end
	end

	// Pulses, status and attention
	always_ff @(posedge mclk_in) begin
		if (!reset_n_in) begin
			pulse_reg    <= 7'h00;
			stat_v_reg   <= 1'b0;
			stat_tag_reg <= 16'h0000;
			att_reg      <= 1'b0;
		end else begin
			pulse_reg    <= pulse_next;
			stat_v_reg   <= stat_v_next;
			stat_tag_reg <= stat_tag_next;
			att_reg      <= att_next;
		end
	end

	// Outputs
	assign flush_out               = pulse_reg[0];
	assign abort_out               = pulse_reg[1];
	assign clear_allegiance_out    = pulse_reg[2];
	assign release_reservation_out = pulse_reg[3];
	assign restore_modes_out       = pulse_reg[4];
	assign reinit_out              = pulse_reg[5];
	assign command_out             = pulse_reg[6];
	assign unit_out                = lun_reg;
	assign link.req_ready          = (state_reg == LRR_T_RECV);
	assign link.rsp_valid          = (state_reg == LRR_T_REPLY);
	assign link.rsp_data           = rsp_byte;
	assign link.rsp_last           = (idx_reg == 4'(lrr_pkg::LRR_RSP_LEN - 1));
	assign link.rsp_path           = path_reg;
	assign link.status_valid       = stat_v_reg;
	assign link.status_tag         = stat_tag_reg;
	assign link.attention          = att_reg;
	assign link.attention_sense    = lrr_pkg::LRR_ASC_POWER_ON;
endmodule

// File: dv/lrr_chk.sv
// Purpose: Link checks between the reset initiator and the target.
// Assumes: One clock, synchronous active-low reset.
// Notes:   Position counters rebuild message bytes from the handshakes.
`timescale 1ns/1ps
module lrr_chk (
	// Clock and reset
	input wire logic        mclk_in,
	input wire logic        reset_n_in,
	// Request and reply streams
	input wire logic        req_valid,
	input wire logic        req_ready,
	input wire logic [7:0]  req_data,
	input wire logic        req_last,
	input wire logic        rsp_valid,
	input wire logic        rsp_ready,
	input wire logic [7:0]  rsp_data,
	input wire logic        rsp_last,
	input wire logic [31:0] rsp_path,
	// Unit attention
	input wire logic        attention,
	input wire logic [7:0]  attention_sense
);
	// ==========================================================
	// Message positions
	logic [3:0]  qpos_reg;
	logic [3:0]  spos_reg;
	logic [15:0] qtag_reg;
	logic [31:0] qpath_reg;
	// Positions restart on each last byte, so a lost marker shows as a bad index
	always_ff @(posedge mclk_in) begin
		if (!reset_n_in) begin
			qpos_reg <= 4'h0;
			spos_reg <= 4'h0;
		end else begin
			if (req_valid && req_ready) begin
				qpos_reg <= req_last ? 4'h0 : qpos_reg + 4'h1;
				if (qpos_reg == 4'h2) qtag_reg[15:8] <= req_data;
				if (qpos_reg == 4'h3) qtag_reg[7:0] <= req_data;
				if (qpos_reg[3:2] == 2'h1) qpath_reg <= {qpath_reg[23:0], req_data};
			end
			if (rsp_valid && rsp_ready) spos_reg <= rsp_last ? 4'h0 : spos_reg + 4'h1;
		end
	end
	// ==========================================================
	// Reply framing and content
	default clocking @(posedge mclk_in); endclocking
	default disable iff (!reset_n_in);
	a_reply_holds: assert property (rsp_valid && !rsp_ready |=> rsp_valid && $stable(rsp_data) && $stable(rsp_path))
		else $error("reply byte changed before it was taken");
	a_reply_header: assert property (rsp_valid && spos_reg < 4'h2 |-> rsp_data == (spos_reg == 4'h0 ? 8'h83 : 8'h03))
		else $error("reply header byte wrong");
	a_tag_echo: assert property (rsp_valid && (spos_reg == 4'h2 || spos_reg == 4'h3) |->
		rsp_data == (spos_reg == 4'h2 ? qtag_reg[15:8] : qtag_reg[7:0]))
		else $error("reply tag differs from request tag");
	a_reply_length: assert property (rsp_valid |-> rsp_last == (spos_reg == 4'h4))
		else $error("reply is not five bytes");
	a_code_defined: assert property (rsp_valid && spos_reg == 4'h4 |-> rsp_data inside {8'h00, 8'h01, 8'h04, 8'h20, 8'hff})
		else $error("reserved return code");
	a_reply_path: assert property (rsp_valid |-> rsp_path == qpath_reg)
		else $error("reply on wrong path");
	// Flush waits are kept short by the bench, so the bound covers them
	a_reply_bound: assert property (req_valid && req_ready && req_last |-> ##[2:300] (rsp_valid && rsp_ready && rsp_last))
		else $error("no reply to request");
	a_no_overlap: assert property (rsp_valid |-> !req_ready)
		else $error("request taken while replying");
	a_sense_code: assert property (attention |-> attention_sense == 8'h29)
		else $error("attention sense code wrong");
	a_attn_sticky: assert property (attention |=> attention)
		else $error("attention dropped");
	c_good_reply: cover property (rsp_valid && spos_reg == 4'h4 && rsp_data == 8'h00);
	c_bad_reply: cover property (rsp_valid && spos_reg == 4'h4 && rsp_data == 8'hff);
	c_attention: cover property ($rose(attention));
endmodule

// File: dv/lun_reset_response_handler_bench.sv
// Purpose: Self-checking bench for both ends of the unit reset link.
// Assumes: Inputs change on the falling edge; random values from a fixed seed.
// Notes:   A second target faces a bench driver that sends an untagged and a simple command.
`timescale 1ns/1ps
`define CHK(n, e, g) begin total_checks++; if ((g) !== (e)) begin miscompares++; $display("unexpected %s expected %h seen %h", n, e, g); end end
module lun_reset_response_handler_bench;
	// ==========================================================
	// Stimulus and observation
	logic                   mclk_in = 1'b0, reset_n_in = 1'b0, start = 1'b0, quiet = 1'b1;
	logic                   pend = 1'b0, tdone = 1'b0, busy, done, flush, abort, clr, rel, rest, reinit, purge, cmd_b;
	logic [15:0]            tag = 16'h0, ttag = 16'h0, stag, seed = 16'h2f20;
	logic [7:0]             lun = 8'h0, tlun = 8'h0, attached = 8'hf7, rcode, plun, unit;
	logic [1:0]             pc = 2'h0;
	logic [3:0][31:0]       paths = '0;
	logic [31:0]            bpath;
	logic [7:0]             bq[$];
	lrr_pkg::lrr_rst_kind_t trst = lrr_pkg::LRR_RST_NONE;
	int                     miscompares = 0, total_checks = 0, nrep, nres, nflush, nre, nst, n, dly, npurge, ncmd;
	lrr_link_if lk ();
	lrr_link_if lb ();
	lrr_initiator i_lrr_initiator (.mclk_in(mclk_in), .reset_n_in(reset_n_in), .start_in(start), .tag_in(tag),
		.lun_in(lun), .path_count_in(pc), .paths_in(paths), .data_quiet_in(quiet), .busy_out(busy),
		.done_out(done), .rcode_out(rcode), .purge_out(purge), .purge_lun_out(plun), .link(lk));
	lrr_target i_lrr_target (.mclk_in(mclk_in), .reset_n_in(reset_n_in), .lun_attached_in(attached),
		.data_pending_in(pend), .task_done_in(tdone), .task_done_tag_in(ttag), .task_done_lun_in(tlun),
		.transport_reset_in(trst), .flush_out(flush), .abort_out(abort), .clear_allegiance_out(clr),
		.release_reservation_out(rel), .restore_modes_out(rest), .unit_out(unit), .reinit_out(reinit),
		.command_out(), .link(lk));
	lrr_target i_lrr_target_b (.mclk_in(mclk_in), .reset_n_in(reset_n_in), .lun_attached_in(attached),
		.data_pending_in(pend), .task_done_in(tdone), .task_done_tag_in(ttag), .task_done_lun_in(tlun),
		.transport_reset_in(trst), .flush_out(), .abort_out(), .clear_allegiance_out(),
		.release_reservation_out(), .restore_modes_out(), .unit_out(), .reinit_out(), .command_out(cmd_b),
		.link(lb));
	lrr_chk i_lrr_chk (.mclk_in(mclk_in), .reset_n_in(reset_n_in), .req_valid(lk.req_valid),
		.req_ready(lk.req_ready), .req_data(lk.req_data), .req_last(lk.req_last), .rsp_valid(lk.rsp_valid),
		.rsp_ready(lk.rsp_ready), .rsp_data(lk.rsp_data), .rsp_last(lk.rsp_last), .rsp_path(lk.rsp_path),
		.attention(lk.attention), .attention_sense(lk.attention_sense));
	// Bench driver side of the second link starts idle
	initial begin
		lb.req_valid = 1'b0;
		lb.req_data = 8'h0;
		lb.req_last = 1'b0;
		lb.req_path = 32'h0;
		lb.rsp_ready = 1'b1;
	end
	always #10 mclk_in = ~mclk_in;
	// Pulse counts and checks at every rising edge
	always @(posedge mclk_in) begin
		if (abort) `CHK("pending_at_abort", 1'b0, pend)
		if (abort) `CHK("unit", lun, unit)
		nres += abort + clr + rel + rest;
		nflush += flush;
		nre += reinit;
		npurge += purge;
		ncmd += cmd_b;
		if (lk.status_valid) begin nst++; stag = lk.status_tag; end
		if (lk.rsp_valid && lk.rsp_ready && lk.rsp_last) nrep++;
		if (lb.rsp_valid && lb.rsp_ready) begin bq.push_back(lb.rsp_data); bpath = lb.rsp_path; end
	end
	// Requested data stops a few cycles after flushing starts
	always @(negedge mclk_in) if (pend && nflush > 0) begin dly++; if (dly == 4) pend = 1'b0; end
	// ==========================================================
	// Tasks
	function automatic logic [15:0] lfsr(input logic [15:0] s);
		return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
	endfunction
	task automatic tick(input int k);
		repeat (k) @(negedge mclk_in);
	endtask
	task automatic results;
		if (miscompares == 0 && total_checks > 0) $display("TEST PASSED");
		else $display("TEST FAILED");
		$finish;
	endtask
	task automatic lun_reset(input logic [7:0] u);
		logic ok;
		seed = lfsr(seed);
		ok = (u < 8'h08) && attached[u[2:0]];
		tag = seed;
		lun = u;
		pc = seed[1:0];
		for (int i = 0; i < 4; i++) paths[i] = {seed, seed ^ 16'(i)};
		nrep = 0; nres = 0; nflush = 0; dly = 0; pend = ok;
		npurge = 0;
		start = 1'b1;
		tick(1);
		start = 1'b0;
		n = 0;
		while (done !== 1'b1 && n < 3000) begin @(posedge mclk_in); n++; end
		if (n == 3000) begin miscompares++; results; end
		tick(2);
		`CHK("rcode", ok ? 8'h00 : 8'hff, rcode)
		`CHK("replies", int'(pc) + 1, nrep)
		`CHK("resets", ok ? 4 * (int'(pc) + 1) : 0, nres)
		if (ok) `CHK("attention", 1'b1, lk.attention)
		if (ok) `CHK("flushed", 1'b1, nflush > 0)
		if (ok) `CHK("purge_unit", u, plun)
		`CHK("purge", 1, npurge)
	endtask
	// Mid-run reset clears the sticky attention, so the next attention check starts from zero
	task automatic rst_pulse;
		reset_n_in = 1'b0;
		tick(1);
		reset_n_in = 1'b1;
		tick(2);
	endtask
	task automatic task_end(input logic [7:0] u, input logic want);
		ttag = seed; tlun = u; tdone = 1'b1; nst = 0;
		tick(1);
		tdone = 1'b0;
		tick(10);
		`CHK("status", want, nst == 1)
		if (want) `CHK("status_tag", ttag, stag)
	endtask
	task automatic treset(input lrr_pkg::lrr_rst_kind_t k);
		rst_pulse;
		nre = 0;
		trst = k;
		tick(1);
		trst = lrr_pkg::LRR_RST_NONE;
		tick(6);
		`CHK("reinit", k != lrr_pkg::LRR_RST_LINK, nre == 1)
		`CHK("attention_after", k != lrr_pkg::LRR_RST_LINK, lk.attention)
	endtask
	// Bytes are held from a falling edge until a rising edge sees ready
	task automatic send_b(input logic [71:0] m);
		lb.req_path = m[39:8];
		for (int i = 0; i < 9; i++) begin
			lb.req_valid = 1'b1;
			lb.req_data = m[71 - 8 * i -: 8];
			lb.req_last = (i == 8);
			n = 0;
			#1;
			while (lb.req_ready !== 1'b1 && n < 50) begin tick(1); #1; n++; end
			if (n == 50) begin miscompares++; results; end
			@(posedge mclk_in);
			tick(1);
		end
		lb.req_valid = 1'b0;
	endtask
	// ==========================================================
	// Main sequence; link reset goes first while attention is still clear
	initial begin
		tick(10);
		reset_n_in = 1'b1;
		tick(2);
		for (int k = 1; k < 6; k++) treset(lrr_pkg::lrr_rst_kind_t'(k));
		quiet = 1'b0;
		start = 1'b1;
		tick(1);
		start = 1'b0;
		tick(3);
		`CHK("busy_unquiet", 1'b0, busy)
		quiet = 1'b1;
		rst_pulse;
		task_end(8'h02, 1'b1);
		lun_reset(8'h02);
		task_end(8'h02, 1'b0);
		task_end(8'h05, 1'b1);
		lun_reset(8'h03);
		lun_reset(8'h09);
		for (int i = 0; i < 6; i++) begin seed = lfsr(seed); lun_reset({5'h0, seed[4:2]}); end
		// Untagged command must be refused, a simple one passes without reply
		bq = {};
		ncmd = 0;
		send_b({8'h83, lrr_pkg::LRR_SUB_COMMAND, seed, seed, ~seed, lrr_pkg::LRR_QCTL_UNTAGGED});
		tick(20);
		`CHK("b_refused", 0, ncmd)
		`CHK("b_reply", {8'h83, 8'h03, seed, 8'hff}, (bq.size() == 5) ? {bq[0], bq[1], bq[2], bq[3], bq[4]} : 40'h0)
		`CHK("b_path", {seed, ~seed}, bpath)
		bq = {};
		ncmd = 0;
		send_b({8'h83, lrr_pkg::LRR_SUB_COMMAND, seed, seed, ~seed, lrr_pkg::LRR_QCTL_SIMPLE});
		tick(20);
		`CHK("b_silent", 0, bq.size())
		`CHK("b_command", 1, ncmd)
		results;
	end
endmodule
